// File: clk_switch_pkg.sv
// Constants, field positions, reset values and types of the clock source switcher.
// Assumes a single 100 MHz bus clock and an AXI4-Lite master with 32-bit data.
package clk_switch_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;

	// Byte addresses on the register bus.
	localparam logic [7:0] ADDR_RUN_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SETTLE_STAT = 8'h04;
	localparam logic [7:0] ADDR_SYS_SEL = 8'h08;
	localparam logic [7:0] ADDR_MODE_CFG = 8'h0c;
	localparam logic [7:0] ADDR_SPEED_CFG = 8'h10;
	localparam logic [7:0] ADDR_FAST_CTRL = 8'h14;
	localparam logic [7:0] ADDR_SETTLE_SEL = 8'h18;
	localparam logic [7:0] ADDR_STATE = 8'h1c;

	// Field positions.
	localparam int unsigned RUN_CRYSTAL_STOP_POS = 7;
	localparam int unsigned RUN_INT_STOP_POS = 0;
	localparam int unsigned SYS_STATUS_POS = 5;
	localparam int unsigned SYS_SOURCE_POS = 4;
	localparam int unsigned SYS_FIXED_POS = 3;
	localparam int unsigned MODE_EXT_POS = 7;
	localparam int unsigned MODE_OSC_SEL_POS = 6;
	localparam int unsigned MODE_GAIN_POS = 0;
	localparam int unsigned SPEED_HS_POS = 0;
	localparam int unsigned FAST_EN_POS = 0;
	localparam int unsigned FAST_SEL_POS = 1;

	// Reset values.
	localparam logic [7:0] SYS_SEL_RESET = 8'h09;
	localparam logic [2:0] DIV_RESET = 3'h1;
	localparam logic CRYSTAL_STOP_RESET = 1'b1;
	localparam logic [2:0] SETTLE_SEL_RESET = 3'h7;

	// Strap code that configures the internal oscillator for 1 MHz.
	localparam logic [1:0] STRAP_IH_1MHZ = 2'h2;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Break-before-make gap while the CPU clock select is changed.
	localparam int unsigned SWITCH_GAP_NS = 20;
	localparam int unsigned SWITCH_GAP_CYCLES_I =
		(SWITCH_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [3:0] SWITCH_GAP_CYCLES = 4'(SWITCH_GAP_CYCLES_I);

	// Settle status bit i is set once 2**SETTLE_LOG2[i] cycles have elapsed.
	localparam logic [7:0][4:0] SETTLE_LOG2 = {5'd8, 5'd9, 5'd10, 5'd11,
		5'd13, 5'd15, 5'd17, 5'd18};
	localparam int unsigned SETTLE_CNT_W = 19;

	typedef enum logic [1:0] {
		SRC_INT = 2'h0,
		SRC_HS = 2'h1,
		SRC_FAST = 2'h2
	} src_t;

	typedef enum logic [7:0] {
		ST_INT_RUN = 8'h01,
		ST_HS_RUN = 8'h02,
		ST_FAST_RUN = 8'h04,
		ST_INT_HALT = 8'h08,
		ST_HS_HALT = 8'h10,
		ST_FAST_HALT = 8'h20,
		ST_INT_STOP = 8'h40,
		ST_HS_STOP = 8'h80
	} state_t;

endpackage : clk_switch_pkg

// File: settle_counter.sv
// Crystal stabilisation time counter with a thermometer status byte.
// Assumes run is high only while the crystal oscillator is enabled.
`timescale 1ns/1ns
module settle_counter #(
	parameter int unsigned SETTLE_SHRINK = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [2:0] limit_sel,
	output logic [7:0] status
);
	import clk_switch_pkg::*;

	typedef struct packed {
		logic [SETTLE_CNT_W-1:0] count;
		logic [7:0] status;
	} cnt_state_t;

	cnt_state_t r;
	cnt_state_t n;

	function automatic logic [SETTLE_CNT_W-1:0] threshold(input logic [4:0] lg);
		threshold = SETTLE_CNT_W'(1) << (lg - 5'(SETTLE_SHRINK));
	endfunction : threshold

	// Counting stops at the selected longest time, so the status never runs past it.
	always_comb begin
		n = r;
		if (!run) begin
			n.count = '0;
		end else if (r.count < threshold(SETTLE_LOG2[3'd7 - limit_sel])) begin
			n.count = r.count + SETTLE_CNT_W'(1);
		end
		for (int i = 0; i < 8; i++) begin
			n.status[i] = (n.count >= threshold(SETTLE_LOG2[i]));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign status = r.status;

endmodule : settle_counter

// File: source_switch.sv
// Break-before-make select of the CPU clock source and divider.
// Assumes the clock gates downstream close while every select is low.
`timescale 1ns/1ns
module source_switch (
	input wire logic aclk,
	input wire logic aresetn,
	input wire clk_switch_pkg::src_t want_src,
	input wire logic [2:0] want_div,
	output logic [2:0] sel_onehot,
	output logic [2:0] div,
	output clk_switch_pkg::src_t cur_src,
	output logic busy
);
	import clk_switch_pkg::*;

	typedef struct packed {
		logic [2:0] sel;
		logic [2:0] div;
		src_t src;
		logic busy;
		logic [3:0] gap;
	} sw_state_t;

	sw_state_t r;
	sw_state_t n;

	// All selects drop for a gap before the new one rises, so no runt pulse reaches the CPU.
	always_comb begin
		n = r;
		if (r.busy) begin
			if (r.gap == 4'h0) begin
				n.sel = 3'h1 << want_src;
				n.src = want_src;
				n.div = want_div;
				n.busy = 1'b0;
			end else begin
				n.gap = r.gap - 4'h1;
			end
		end else if (want_src != r.src || want_div != r.div) begin
			n.sel = 3'h0;
			n.busy = 1'b1;
			n.gap = SWITCH_GAP_CYCLES - 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.sel <= 3'h1;
			r.div <= DIV_RESET;
			r.src <= SRC_INT;
		end else begin
			r <= n;
		end
	end

	assign sel_onehot = r.sel;
	assign div = r.div;
	assign cur_src = r.src;
	assign busy = r.busy;

endmodule : source_switch

// File: cpu_clock_source_switcher.sv
// CPU clock source switcher: registers, legal transitions, run/halt/stop states.
// Assumes an AXI4-Lite master on aclk and same-clock halt and stop requests from the CPU.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module cpu_clock_source_switcher #(
	parameter int unsigned SETTLE_SHRINK = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] strap_ih_freq,
	input wire logic halt_req,
	input wire logic stop_req,
	input wire logic wake_pin,
	output logic int_osc_en,
	output logic crystal_osc_en,
	output logic ext_clk_en,
	output logic crystal_gain,
	output logic fast_osc_en,
	output logic high_speed_mode,
	output logic ih_osc_8mhz,
	output logic [2:0] clk_sel,
	output logic [2:0] clk_div,
	output logic cpu_halted,
	output logic cpu_stopped
);
	import clk_switch_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		state_t state;
		logic strap_taken;
		logic ih_1mhz;
		logic crystal_stop;
		logic int_stop;
		logic main_src_bit;
		logic [2:0] div;
		logic mode_written;
		logic ext_in;
		logic osc_sel;
		logic gain;
		logic hs_op;
		logic fast_en;
		logic fast_sel;
		logic [2:0] settle_sel;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0] wake_sync;
		logic int_en;
		logic crystal_en;
		logic ext_en;
		logic halted;
		logic stopped;
		logic fast_run;
		logic ih_8mhz;
	} regs_t;

	regs_t r;
	regs_t n;

	src_t want_src;
	src_t cur_src;
	logic [2:0] sel_onehot;
	logic [2:0] div_applied;
	logic [7:0] settle_status;
	logic hs_status;
	logic wake_seen;
	logic do_write;
	logic [7:0] wd;
	logic [7:0] rd;
	logic rd_ok;
	logic wr_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules.

	source_switch u_switch (
		.aclk(aclk),
		.aresetn(aresetn),
		.want_src(want_src),
		.want_div(r.div),
		.sel_onehot(sel_onehot),
		.div(div_applied),
		.cur_src(cur_src),
		.busy()
	);

	// The counter runs only while the crystal really oscillates; an external clock
	// needs no settling, so it is not counted.
	settle_counter #(
		.SETTLE_SHRINK(SETTLE_SHRINK)
	) u_settle (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(r.crystal_en),
		.limit_sel(r.settle_sel),
		.status(settle_status)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	assign hs_status = (cur_src == SRC_HS);
	assign wake_seen = r.wake_sync[1] & r.wake_sync[2];
	assign do_write = r.aw_held & r.w_held & ~r.bvalid;
	assign wd = r.w_data;

	// The 20 MHz select wins over the source bit; the write guards keep both from being set.
	always_comb begin
		if (r.fast_sel) begin
			want_src = SRC_FAST;
		end else if (r.main_src_bit) begin
			want_src = SRC_HS;
		end else begin
			want_src = SRC_INT;
		end
	end

	always_comb begin
		rd = 8'h00;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			ADDR_RUN_CTRL: begin
				rd[RUN_CRYSTAL_STOP_POS] = r.crystal_stop;
				rd[RUN_INT_STOP_POS] = r.int_stop;
			end
			ADDR_SETTLE_STAT: begin
				rd = settle_status;
			end
			ADDR_SYS_SEL: begin
				rd[SYS_STATUS_POS] = hs_status;
				rd[SYS_SOURCE_POS] = r.main_src_bit;
				rd[SYS_FIXED_POS] = SYS_SEL_RESET[SYS_FIXED_POS];
				rd[2:0] = r.div;
			end
			ADDR_MODE_CFG: begin
				rd[MODE_EXT_POS] = r.ext_in;
				rd[MODE_OSC_SEL_POS] = r.osc_sel;
				rd[MODE_GAIN_POS] = r.gain;
			end
			ADDR_SPEED_CFG: begin
				rd[SPEED_HS_POS] = r.hs_op;
			end
			ADDR_FAST_CTRL: begin
				rd[FAST_EN_POS] = r.fast_en;
				rd[FAST_SEL_POS] = r.fast_sel;
			end
			ADDR_SETTLE_SEL: begin
				rd[2:0] = r.settle_sel;
			end
			ADDR_STATE: begin
				rd = r.state;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		n = r;
		wr_ok = 1'b1;

		// Strap is caught once, in the first cycle after reset release.
		if (!r.strap_taken) begin
			n.strap_taken = 1'b1;
			n.ih_1mhz = (strap_ih_freq == STRAP_IH_1MHZ);
		end

		// Wake pin crosses in by three flops; it counts once the last two are both high.
		n.wake_sync = {r.wake_sync[1:0], wake_pin};

		// Write address and data channels, taken in either order.
		if (s_axi_awvalid && r.awready) begin
			n.aw_held = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.w_held = 1'b1;
			n.w_data = s_axi_wdata[7:0];
			n.w_lane0 = s_axi_wstrb[0];
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end

		if (do_write) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			unique case (r.aw_addr)
				ADDR_RUN_CTRL: begin
					if (r.w_lane0) begin
						// Stopping the crystal under a CPU that runs on it is refused.
						if (!wd[RUN_CRYSTAL_STOP_POS] || !hs_status) begin
							n.crystal_stop = wd[RUN_CRYSTAL_STOP_POS];
						end
						if (!wd[RUN_INT_STOP_POS] || hs_status) begin
							n.int_stop = wd[RUN_INT_STOP_POS];
						end
					end
				end
				ADDR_SETTLE_STAT: begin
					wr_ok = 1'b1;
				end
				ADDR_SYS_SEL: begin
					if (r.w_lane0) begin
						n.div = wd[2:0];
						// No direct hop between the 20 MHz and high-speed sources.
						if (!r.fast_sel && r.osc_sel) begin
							n.main_src_bit = wd[SYS_SOURCE_POS];
						end
					end
				end
				ADDR_MODE_CFG: begin
					if (r.w_lane0 && !r.mode_written) begin
						n.mode_written = 1'b1;
						n.ext_in = wd[MODE_EXT_POS];
						n.osc_sel = wd[MODE_OSC_SEL_POS];
						n.gain = wd[MODE_GAIN_POS];
					end
				end
				ADDR_SPEED_CFG: begin
					if (r.w_lane0) begin
						n.hs_op = wd[SPEED_HS_POS];
					end
				end
				ADDR_FAST_CTRL: begin
					if (r.w_lane0 && !r.ih_1mhz) begin
						// Disabling is refused while the 20 MHz select bit is set, or when the same write sets it.
						if (wd[FAST_EN_POS] || !wd[FAST_SEL_POS] && !r.fast_sel) begin
							n.fast_en = wd[FAST_EN_POS];
						end
						if (!wd[FAST_SEL_POS] || r.fast_en && !r.main_src_bit && !hs_status) begin
							n.fast_sel = wd[FAST_SEL_POS];
						end
					end
				end
				ADDR_SETTLE_SEL: begin
					if (r.w_lane0) begin
						n.settle_sel = wd[2:0];
					end
				end
				ADDR_STATE: begin
					wr_ok = 1'b1;
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// The 1 MHz configuration forbids the 20 MHz oscillator outright.
		if (n.ih_1mhz) begin
			n.fast_en = 1'b0;
			n.fast_sel = 1'b0;
		end

		n.awready = ~n.aw_held & ~n.bvalid;
		n.wready = ~n.w_held & ~n.bvalid;

		// Read channel: one read at a time, answered one cycle after it is taken.
		if (s_axi_arvalid && r.arready) begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = {24'h000000, rd};
			n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end else if (!r.rvalid) begin
			n.arready = 1'b1;
		end

		// CPU clock states follow the source actually applied, not the one requested.
		unique case (r.state)
			ST_INT_RUN, ST_HS_RUN, ST_FAST_RUN: begin
				if (halt_req) begin
					unique case (cur_src)
						SRC_HS: n.state = ST_HS_HALT;
						SRC_FAST: n.state = ST_FAST_HALT;
						default: n.state = ST_INT_HALT;
					endcase
				end else if (stop_req && cur_src != SRC_FAST) begin
					n.state = (cur_src == SRC_HS) ? ST_HS_STOP : ST_INT_STOP;
				end else begin
					unique case (cur_src)
						SRC_HS: n.state = ST_HS_RUN;
						SRC_FAST: n.state = ST_FAST_RUN;
						default: n.state = ST_INT_RUN;
					endcase
				end
			end
			ST_INT_HALT, ST_INT_STOP: begin
				if (wake_seen) begin
					n.state = ST_INT_RUN;
				end
			end
			ST_HS_HALT, ST_HS_STOP: begin
				if (wake_seen) begin
					n.state = ST_HS_RUN;
				end
			end
			ST_FAST_HALT: begin
				if (wake_seen) begin
					n.state = ST_FAST_RUN;
				end
			end
			default: begin
				n.state = ST_INT_RUN;
			end
		endcase

		n.halted = (n.state == ST_INT_HALT) | (n.state == ST_HS_HALT) | (n.state == ST_FAST_HALT);
		n.stopped = (n.state == ST_INT_STOP) | (n.state == ST_HS_STOP);

		// Oscillator enables. STOP freezes every main oscillator until wake.
		n.int_en = ~n.int_stop & ~n.stopped;
		n.crystal_en = n.osc_sel & ~n.ext_in & ~n.crystal_stop & ~n.stopped;
		n.ext_en = n.osc_sel & n.ext_in & ~n.crystal_stop & ~n.stopped;
		n.fast_run = n.fast_en & ~n.stopped;
		n.ih_8mhz = ~n.ih_1mhz;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.state <= ST_INT_RUN;
			r.div <= SYS_SEL_RESET[2:0];
			r.crystal_stop <= CRYSTAL_STOP_RESET;
			r.settle_sel <= SETTLE_SEL_RESET;
			// The CPU runs on the internal oscillator straight out of reset.
			r.int_en <= 1'b1;
			r.ih_8mhz <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign int_osc_en = r.int_en;
	assign crystal_osc_en = r.crystal_en;
	assign ext_clk_en = r.ext_en;
	assign crystal_gain = r.gain;
	assign fast_osc_en = r.fast_run;
	assign high_speed_mode = r.hs_op;
	assign ih_osc_8mhz = r.ih_8mhz;
	// The switch already holds every select low for the whole gap.
	assign clk_sel = sel_onehot;
	assign clk_div = div_applied;
	assign cpu_halted = r.halted;
	assign cpu_stopped = r.stopped;

endmodule : cpu_clock_source_switcher

// File: cpu_clock_source_switcher_props.sv
// Port-level checks of the clock source switcher: select, enables, halt and stop.
// Assumes it is bound into cpu_clock_source_switcher and sees only its ports.
`timescale 1ns/1ns
module cpu_clock_source_switcher_props #(
	parameter int unsigned SETTLE_SHRINK = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic halt_req,
	input wire logic stop_req,
	input wire logic int_osc_en,
	input wire logic crystal_osc_en,
	input wire logic ext_clk_en,
	input wire logic fast_osc_en,
	input wire logic ih_osc_8mhz,
	input wire logic [2:0] clk_sel,
	input wire logic [2:0] clk_div,
	input wire logic cpu_halted,
	input wire logic cpu_stopped
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	AST_RESET_SEL: assert property ($rose(aresetn) |-> clk_sel == 3'b001 && clk_div == 3'h1)
		else $error("clock select or divider not at reset value");
	AST_RESET_RATE: assert property ($rose(aresetn) |-> ih_osc_8mhz)
		else $error("internal rate flag low right after reset");
	AST_SEL_ONEHOT: assert property ($onehot0(clk_sel))
		else $error("more than one clock source applied");
	// A change of source without the idle gap could glitch the CPU clock.
	AST_NO_DIRECT: assert property ((clk_sel != 3'b000 && $past(clk_sel) != 3'b000)
		|-> clk_sel == $past(clk_sel))
		else $error("source changed without idle gap");
	AST_GAP_LEN: assert property ($fell(|clk_sel) |-> ##1 clk_sel == 3'b000
		##[1:2] clk_sel != 3'b000)
		else $error("idle gap of wrong length");
	AST_FAST_1MHZ: assert property (!ih_osc_8mhz |-> !fast_osc_en && !clk_sel[2])
		else $error("fast oscillator used with slow internal setting");
	AST_XTAL_EXT: assert property (!(crystal_osc_en && ext_clk_en))
		else $error("crystal and external input enabled together");
	AST_INT_STOP: assert property ($fell(int_osc_en) && !cpu_stopped |-> clk_sel == 3'b010)
		else $error("internal oscillator stopped while not on crystal");
	AST_XTAL_STOP: assert property ($fell(crystal_osc_en) |-> !clk_sel[1] || cpu_stopped)
		else $error("crystal stopped while it clocks the CPU");
	AST_HALT: assert property (halt_req && !cpu_halted && !cpu_stopped |=> cpu_halted)
		else $error("halt request not taken");
	AST_STOP_FAST: assert property (stop_req && !halt_req && clk_sel[2] |=> !cpu_stopped)
		else $error("stop entered from fast oscillator");
	AST_STOP_ENTER: assert property (stop_req && !halt_req && (clk_sel[0] || clk_sel[1])
		&& !cpu_halted && !cpu_stopped |=> cpu_stopped)
		else $error("stop request not taken");
endmodule : cpu_clock_source_switcher_props

bind cpu_clock_source_switcher cpu_clock_source_switcher_props #(
	.SETTLE_SHRINK(SETTLE_SHRINK)) u_props (.aclk, .aresetn, .halt_req, .stop_req, .int_osc_en,
	.crystal_osc_en, .ext_clk_en, .fast_osc_en, .ih_osc_8mhz, .clk_sel, .clk_div, .cpu_halted,
	.cpu_stopped);

// File: cpu_clock_source_switcher_tb_top.sv
// Self-checking bench of the clock source switcher, driven over AXI4-Lite.
// Assumes settle counts shrunk by SETTLE_SHRINK and a 100 MHz aclk.
`timescale 1ns/1ns
module cpu_clock_source_switcher_tb_top;
	import clk_switch_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic halt_req = 1'b0, stop_req = 1'b0, wake_pin = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd_val;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0086988f;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] strap_ih_freq = 2'h0, s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic int_osc_en, crystal_osc_en, ext_clk_en, crystal_gain, fast_osc_en, high_speed_mode;
	logic ih_osc_8mhz, cpu_halted, cpu_stopped;
	logic [2:0] clk_sel, clk_div;
	int mismatches = 0, checks_done = 0;
	// Model of the select register: requested source, divider, oscillator select.
	int m_src, m_div, m_osc, m_high_speed_operation_bit;
	always #5 aclk = ~aclk;
	cpu_clock_source_switcher #(.SETTLE_SHRINK(6)) DUT (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_ih_freq, .halt_req,
		.stop_req, .wake_pin, .int_osc_en, .crystal_osc_en, .ext_clk_en, .crystal_gain,
		.fast_osc_en, .high_speed_mode, .ih_osc_8mhz, .clk_sel, .clk_div, .cpu_halted,
		.cpu_stopped);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0s expected %h seen %h", what, exp, got);
		end
	endtask : chk_resp
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	task automatic note(input string name);
		$display("test %0s done", name);
	endtask : note
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1) break;
			if (s_axi_awready === 1'b1) aw = 1'b0;
			if (s_axi_wready === 1'b1) w = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'b0;
		chk_resp("write response", RESP_OKAY, s_axi_bresp);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_rvalid === 1'b1) break;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		rd_val = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rck(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk_resp("read response", RESP_OKAY, rsp);
		chk("register read", exp, rd_val);
	endtask : rck
	task automatic gap();
		repeat (8) @(posedge aclk);
	endtask : gap
	task automatic do_reset(input logic [1:0] strap);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap_ih_freq <= strap;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		m_src = 0;
		m_div = 1;
		m_osc = 0;
		m_high_speed_operation_bit = 0;
	endtask : do_reset
	// Writes a random divider with the given source; a refused source keeps the old one.
	task automatic wsys(input int src);
		seed = xs(seed);
		m_div = int'(seed[2:0]);
		if (m_high_speed_operation_bit == 0 && m_osc == 1) m_src = src;
		wr(ADDR_SYS_SEL, {3'b000, 1'(src), 1'b1, 3'(m_div)});
		gap();
		chk("applied divider", 8'(m_div), 8'(clk_div));
		rck(ADDR_SYS_SEL, {2'b00, 1'(m_src), 1'(m_src), 1'b1, 3'(m_div)});
	endtask : wsys
	task automatic ev(input logic stop, input logic [7:0] st, input logic [7:0] back);
		@(posedge aclk);
		halt_req <= !stop;
		stop_req <= stop;
		@(posedge aclk);
		halt_req <= 1'b0;
		stop_req <= 1'b0;
		rck(ADDR_STATE, st);
		chk("halt levels", {6'h0, |(st & 8'hc0), |(st & 8'h38)}, {6'h0, cpu_stopped, cpu_halted});
		wake_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		wake_pin <= 1'b0;
		rck(ADDR_STATE, back);
	endtask : ev
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#1_000_000;
		mismatches++;
		$display("Error watchdog expected end seen hang");
		finish_test();
	end
	initial begin
		do_reset(2'h0);
		chk("internal rate", 8'h1, 8'(ih_osc_8mhz));
		chk("reset select", 8'h1, 8'(clk_sel));
		rck(ADDR_SYS_SEL, SYS_SEL_RESET);
		rck(ADDR_RUN_CTRL, 8'h80);
		rck(ADDR_SETTLE_SEL, 8'h07);
		rck(ADDR_SETTLE_STAT, 8'h00);
		rck(ADDR_STATE, ST_INT_RUN);
		rd(8'h20);
		chk_resp("unmapped read", RESP_SLVERR, rsp);
		note("reset");
		// Without the oscillator select bit the source bit must be refused.
		for (int i = 0; i < 3; i++) wsys(1);
		wr(ADDR_MODE_CFG, 8'h41);
		m_osc = 1;
		wr(ADDR_MODE_CFG, 8'hc0);
		wr(ADDR_RUN_CTRL, 8'h00);
		gap();
		chk("crystal enable", 8'h1, 8'(crystal_osc_en));
		chk("external input", 8'h0, 8'(ext_clk_en));
		chk("crystal gain", 8'h1, 8'(crystal_gain));
		rd_val = 8'h00;
		while (rd_val[5] !== 1'b1) rd(ADDR_SETTLE_STAT);
		chk("settle status", 8'he0, rd_val & 8'he1);
		wr(ADDR_SPEED_CFG, 8'h01);
		chk("high speed mode", 8'h1, 8'(high_speed_mode));
		wsys(1);
		chk("crystal applied", 8'h2, 8'(clk_sel));
		rck(ADDR_STATE, ST_HS_RUN);
		note("crystal switch");
		wr(ADDR_RUN_CTRL, 8'h81);
		gap();
		chk("internal stop", 8'h0, 8'(int_osc_en));
		chk("crystal kept", 8'h1, 8'(crystal_osc_en));
		wr(ADDR_FAST_CTRL, 8'h01);
		wr(ADDR_FAST_CTRL, 8'h03);
		rck(ADDR_FAST_CTRL, 8'h01);
		ev(1'b0, ST_HS_HALT, ST_HS_RUN);
		ev(1'b1, ST_HS_STOP, ST_HS_RUN);
		wr(ADDR_RUN_CTRL, 8'h00);
		gap();
		chk("internal restart", 8'h1, 8'(int_osc_en));
		repeat (1000) @(posedge aclk);
		wsys(0);
		chk("internal applied", 8'h1, 8'(clk_sel));
		wr(ADDR_RUN_CTRL, 8'h80);
		gap();
		chk("crystal stop", 8'h0, 8'(crystal_osc_en));
		note("return");
		repeat (10000) @(posedge aclk);
		wr(ADDR_FAST_CTRL, 8'h03);
		m_high_speed_operation_bit = 1;
		gap();
		chk("fast applied", 8'h4, 8'(clk_sel));
		rck(ADDR_STATE, ST_FAST_RUN);
		ev(1'b1, ST_FAST_RUN, ST_FAST_RUN);
		ev(1'b0, ST_FAST_HALT, ST_FAST_RUN);
		wsys(1);
		chk("fast kept", 8'h4, 8'(clk_sel));
		wr(ADDR_FAST_CTRL, 8'h01);
		m_high_speed_operation_bit = 0;
		gap();
		chk("fast left", 8'h1, 8'(clk_sel));
		wr(ADDR_FAST_CTRL, 8'h00);
		gap();
		chk("fast stopped", 8'h0, 8'(fast_osc_en));
		ev(1'b0, ST_INT_HALT, ST_INT_RUN);
		ev(1'b1, ST_INT_STOP, ST_INT_RUN);
		note("fast and states");
		do_reset(STRAP_IH_1MHZ);
		chk("internal rate", 8'h0, 8'(ih_osc_8mhz));
		rck(ADDR_SYS_SEL, SYS_SEL_RESET);
		wr(ADDR_FAST_CTRL, 8'h01);
		wr(ADDR_FAST_CTRL, 8'h03);
		gap();
		chk("fast locked out", 8'h0, {7'h0, fast_osc_en});
		chk("select locked out", 8'h1, 8'(clk_sel));
		wr(ADDR_MODE_CFG, 8'hc0);
		m_osc = 1;
		wr(ADDR_RUN_CTRL, 8'h00);
		gap();
		chk("external enable", 8'h1, 8'(ext_clk_en));
		chk("crystal off", 8'h0, 8'(crystal_osc_en));
		wsys(1);
		chk("external applied", 8'h2, 8'(clk_sel));
		note("slow strap");
		finish_test();
	end
endmodule : cpu_clock_source_switcher_tb_top
